// *** include/xbar_params.svh ***
// register map and constants for the crossbar and sync retimer
`ifndef XBAR_PARAMS_SVH
`define XBAR_PARAMS_SVH
// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define RA_XBAR_BASE   8'h20
`define RA_TG_CTRL     8'h40
`define RA_TG_HIGH     8'h41
`define RA_TG_LOW      8'h42
`define RA_TG_LINES    8'h43
`define RA_TG_DELAY    8'h44
`define RA_TG_STATUS   8'h45
`define RA_TG_HSHIGH   8'h46
`define RA_TG_HSLOW    8'h47
// ------------------------------------------------------------
// control fields and reset values
// ------------------------------------------------------------
`define CTRL_MODE_LSB  0
`define CTRL_REGEN_LSB 2
`define LOCK_COUNT     2'h3
`define TG_HIGH_RST    24'h00_0010
`define TG_LOW_RST     24'h00_0100
`define TG_LINES_RST   24'h00_0004
`define TG_DELAY_RST   24'h00_0000
`define TG_HSH_RST     24'h00_0008
`define TG_HSL_RST     24'h00_0020
`endif

// *** include/xbar_pkg.sv ***
// types for the crossbar and sync retimer
package xbar_pkg;
   typedef enum logic [1:0] {
      MODE_OFF    = 2'b00,
      MODE_TRACK  = 2'b01,
      MODE_SINGLE = 2'b10,
      MODE_AUTO   = 2'b11
   } tg_mode_t;
   typedef enum logic [1:0] {
      FR_IDLE  = 2'b00,
      FR_DELAY = 2'b01,
      FR_HIGH  = 2'b10,
      FR_LOW   = 2'b11
   } frame_state_t;
endpackage

// *** design/route_mux.sv ***
// one crossbar output slot: selects any input bit
`timescale 1ns/1ps
module route_mux
   import xbar_pkg::*;
#(
   parameter int N_IN  = 32,
   parameter int SEL_W = 5
) (
   // inputs and selection
   input  wire logic [N_IN-1:0]  route_input_slot,
   input  wire logic [SEL_W-1:0] sel,
   // selected bit
   output logic                  bit_out
);
   // out of range select reads zero rather than garbage
   always_comb begin
      bit_out = 1'b0;
      if (int'(sel) < N_IN) begin
         bit_out = route_input_slot[sel];
      end
   end
endmodule

// *** design/video_crossbar_sync_retimer.sv ***
// crossbar for video input bits and sync timing generator
`timescale 1ns/1ps
`include "xbar_params.svh"
module video_crossbar_sync_retimer
   import xbar_pkg::*;
#(
   parameter int N_IN  = 32,
   parameter int N_OUT = 32,
   parameter int SEL_W = 5,
   parameter int CNT_W = 24
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // register port
   input  wire logic [7:0]       reg_addr,
   input  wire logic [31:0]      reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [31:0]      reg_rdata_ff,
   // parallel video input, syncs included
   input  wire logic [N_IN-1:0]  route_input_slot,
   // routed words; top two slots carry vsync and hsync
   output logic      [N_OUT-1:0] route_output_slot_ff,
   output logic                  locked_ff
);
   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   logic [SEL_W-1:0] sel_ff [N_OUT];   // per slot select
   tg_mode_t         mode_ff;          // trigger mode
   logic [1:0]       regen_ff;         // bit0 vsync, bit1 hsync
   logic [CNT_W-1:0] high_ff;          // vsync high cycles
   logic [CNT_W-1:0] low_ff;           // vsync low cycles
   logic [CNT_W-1:0] lines_ff;         // hsync pulses per frame
   logic [CNT_W-1:0] delay_ff;         // delay after input vsync
   logic [CNT_W-1:0] hsh_ff;           // hsync high cycles
   logic [CNT_W-1:0] hsl_ff;           // hsync low cycles

   // default select: slot i takes input i, syncs on the msbs
   function automatic logic [SEL_W-1:0] dflt_sel(input int i);
      dflt_sel = SEL_W'(i % N_IN);
   endfunction

   // register address match for fixed offsets
   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] r);
      hit = (a == r);
   endfunction

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   // reset routing: each slot back to its own input
   always_ff @(posedge clk) begin
      for (int i = 0; i < N_OUT; i++) begin
         if (!resetn) begin
            sel_ff[i] <= dflt_sel(i);
         end else if (reg_wr && reg_addr == 8'(`RA_XBAR_BASE + i)) begin
            sel_ff[i] <= reg_wdata[SEL_W-1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         mode_ff  <= MODE_OFF;
         regen_ff <= 2'h0;
         high_ff  <= CNT_W'(`TG_HIGH_RST);
         low_ff   <= CNT_W'(`TG_LOW_RST);
         lines_ff <= CNT_W'(`TG_LINES_RST);
         delay_ff <= CNT_W'(`TG_DELAY_RST);
         hsh_ff   <= CNT_W'(`TG_HSH_RST);
         hsl_ff   <= CNT_W'(`TG_HSL_RST);
      end else if (reg_wr) begin
         if (hit(reg_addr, `RA_TG_CTRL)) begin
            mode_ff  <= tg_mode_t'(reg_wdata[`CTRL_MODE_LSB +: 2]);
            regen_ff <= reg_wdata[`CTRL_REGEN_LSB +: 2];
         end
         if (hit(reg_addr, `RA_TG_HIGH))   high_ff  <= reg_wdata[CNT_W-1:0];
         if (hit(reg_addr, `RA_TG_LOW))    low_ff   <= reg_wdata[CNT_W-1:0];
         if (hit(reg_addr, `RA_TG_LINES))  lines_ff <= reg_wdata[CNT_W-1:0];
         if (hit(reg_addr, `RA_TG_DELAY))  delay_ff <= reg_wdata[CNT_W-1:0];
         if (hit(reg_addr, `RA_TG_HSHIGH)) hsh_ff   <= reg_wdata[CNT_W-1:0];
         if (hit(reg_addr, `RA_TG_HSLOW))  hsl_ff   <= reg_wdata[CNT_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // crossbar
   // ------------------------------------------------------------
   logic [N_OUT-1:0] routed;   // combinational mux outputs

   for (genvar g = 0; g < N_OUT; g++) begin : g_mux
      route_mux #(.N_IN(N_IN), .SEL_W(SEL_W)) u_mux (
         .route_input_slot (route_input_slot),
         .sel              (sel_ff[g]),
         .bit_out          (routed[g])
      );
   end

   // routed vsync and hsync come from the top two slots
   logic vs_in;
   logic hs_in;
   assign vs_in = routed[N_OUT-1];
   assign hs_in = routed[N_OUT-2];

   logic vs_prev_ff;   // previous input vsync for edge detect
   always_ff @(posedge clk) begin
      if (!resetn) vs_prev_ff <= 1'b0;
      else         vs_prev_ff <= vs_in;
   end
   logic vs_rise;
   logic vs_fall;
   assign vs_rise = vs_in & ~vs_prev_ff;
   assign vs_fall = ~vs_in & vs_prev_ff;

   // ------------------------------------------------------------
   // tracking: measure input waveform
   // ------------------------------------------------------------
   logic [CNT_W-1:0] mhi_ff;     // running high count
   logic [CNT_W-1:0] mlo_ff;     // running low count
   logic [CNT_W-1:0] cand_hi_ff; // candidate waveform
   logic [CNT_W-1:0] cand_lo_ff;
   logic [CNT_W-1:0] lk_hi_ff;   // locked waveform
   logic [CNT_W-1:0] lk_lo_ff;
   logic [1:0]       same_ff;    // consecutive matching candidates
   logic [1:0]       diff_ff;    // consecutive mismatches to lock

   always_ff @(posedge clk) begin
      if (!resetn) begin
         mhi_ff <= '0;
         mlo_ff <= '0;
      end else if (vs_rise) begin
         mhi_ff <= CNT_W'(1);
         mlo_ff <= '0;
      end else if (vs_in) begin
         mhi_ff <= mhi_ff + CNT_W'(1);
      end else begin
         mlo_ff <= mlo_ff + CNT_W'(1);
      end
   end

   // a period closes at each rising edge of input vsync
   logic per_done;
   logic per_same;
   logic per_lock;
   assign per_done = vs_rise && mode_ff == MODE_TRACK;
   assign per_same = mhi_ff == cand_hi_ff && mlo_ff == cand_lo_ff;
   assign per_lock = mhi_ff == lk_hi_ff && mlo_ff == lk_lo_ff;

   always_ff @(posedge clk) begin
      if (!resetn || mode_ff != MODE_TRACK) begin
         cand_hi_ff <= '0;
         cand_lo_ff <= '0;
         lk_hi_ff   <= '0;
         lk_lo_ff   <= '0;
         same_ff    <= 2'h0;
         diff_ff    <= 2'h0;
         locked_ff  <= 1'b0;
      end else if (per_done) begin
         cand_hi_ff <= mhi_ff;
         cand_lo_ff <= mlo_ff;
         // count of identical waveforms seen in a row
         if (per_same && same_ff != `LOCK_COUNT) begin
            same_ff <= same_ff + 2'h1;
         end else if (!per_same) begin
            same_ff <= 2'h1;
         end
         if (!locked_ff) begin
            if (per_same && same_ff >= `LOCK_COUNT - 2'h1) begin
               locked_ff <= 1'b1;
               lk_hi_ff  <= mhi_ff;
               lk_lo_ff  <= mlo_ff;
               diff_ff   <= 2'h0;
            end
         end else if (per_lock) begin
            diff_ff <= 2'h0;
         end else if (diff_ff == `LOCK_COUNT - 2'h1) begin
            // drop lock; candidate run keeps its count, so relock can follow at once
            locked_ff <= 1'b0;
            diff_ff   <= 2'h0;
         end else begin
            diff_ff <= diff_ff + 2'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // frame generator
   // ------------------------------------------------------------
   frame_state_t     st_ff;      // frame phase
   logic [CNT_W-1:0] cnt_ff;     // phase cycle counter
   logic [CNT_W-1:0] eff_hi;     // active vsync high length
   logic [CNT_W-1:0] eff_lo;     // active vsync low length
   logic             trig;       // start a frame now
   logic             reloop;     // frame end restarts on its own

   assign eff_hi = (mode_ff == MODE_TRACK) ? lk_hi_ff : high_ff;
   assign eff_lo = (mode_ff == MODE_TRACK) ? lk_lo_ff : low_ff;

   always_comb begin
      trig   = 1'b0;
      reloop = 1'b0;
      unique case (mode_ff)
         MODE_SINGLE: trig = vs_rise;
         MODE_AUTO: begin
            trig   = vs_rise;
            reloop = 1'b1;
         end
         // locked tracker only starts once, then loops itself
         MODE_TRACK: begin
            trig   = locked_ff && st_ff == FR_IDLE && vs_rise;
            reloop = locked_ff;
         end
         MODE_OFF: trig = 1'b0;
      endcase
   end

   // zero delay skips the delay phase
   function automatic frame_state_t start_st(input logic [CNT_W-1:0] d);
      start_st = (d == '0) ? FR_HIGH : FR_DELAY;
   endfunction

   always_ff @(posedge clk) begin
      if (!resetn || mode_ff == MODE_OFF) begin
         st_ff  <= FR_IDLE;
         cnt_ff <= '0;
      end else if (trig) begin
         st_ff  <= start_st(delay_ff);
         cnt_ff <= CNT_W'(1);
      end else begin
         unique case (st_ff)
            FR_IDLE: cnt_ff <= '0;
            FR_DELAY: begin
               if (cnt_ff >= delay_ff) begin
                  st_ff  <= FR_HIGH;
                  cnt_ff <= CNT_W'(1);
               end else begin
                  cnt_ff <= cnt_ff + CNT_W'(1);
               end
            end
            FR_HIGH: begin
               if (cnt_ff >= eff_hi) begin
                  st_ff  <= FR_LOW;
                  cnt_ff <= CNT_W'(1);
               end else begin
                  cnt_ff <= cnt_ff + CNT_W'(1);
               end
            end
            FR_LOW: begin
               if (cnt_ff >= eff_lo) begin
                  st_ff  <= reloop ? FR_HIGH : FR_IDLE;
                  cnt_ff <= CNT_W'(1);
               end else begin
                  cnt_ff <= cnt_ff + CNT_W'(1);
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // derived hsync: lines pulses during vsync low
   // ------------------------------------------------------------
   logic [CNT_W-1:0] hcnt_ff;    // cycles within a line
   logic [CNT_W-1:0] line_ff;    // lines emitted this frame
   logic             gen_hs;

   always_ff @(posedge clk) begin
      if (!resetn || st_ff != FR_LOW) begin
         hcnt_ff <= '0;
         line_ff <= '0;
      end else if (hcnt_ff >= hsh_ff + hsl_ff - CNT_W'(1)) begin
         hcnt_ff <= '0;
         line_ff <= line_ff + CNT_W'(1);
      end else begin
         hcnt_ff <= hcnt_ff + CNT_W'(1);
      end
   end
   assign gen_hs = st_ff == FR_LOW && line_ff < lines_ff && hcnt_ff < hsh_ff;

   // ------------------------------------------------------------
   // output stage
   // ------------------------------------------------------------
   logic gen_vs;
   assign gen_vs = st_ff == FR_HIGH;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         route_output_slot_ff <= '0;
      end else begin
         route_output_slot_ff <= routed;
         route_output_slot_ff[N_OUT-1] <= regen_ff[0] ? gen_vs : vs_in;
         route_output_slot_ff[N_OUT-2] <= regen_ff[1] ? gen_hs : hs_in;
      end
   end

   // ------------------------------------------------------------
   // register reads, data valid the cycle after the strobe
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         reg_rdata_ff <= '0;
      end else begin
         reg_rdata_ff <= '0;
         if (reg_rd) begin
            for (int i = 0; i < N_OUT; i++) begin
               if (reg_addr == 8'(`RA_XBAR_BASE + i))
                  reg_rdata_ff <= 32'(sel_ff[i]);
            end
            if (hit(reg_addr, `RA_TG_CTRL))
               reg_rdata_ff <= 32'({regen_ff, mode_ff});
            if (hit(reg_addr, `RA_TG_HIGH))   reg_rdata_ff <= 32'(high_ff);
            if (hit(reg_addr, `RA_TG_LOW))    reg_rdata_ff <= 32'(low_ff);
            if (hit(reg_addr, `RA_TG_LINES))  reg_rdata_ff <= 32'(lines_ff);
            if (hit(reg_addr, `RA_TG_DELAY))  reg_rdata_ff <= 32'(delay_ff);
            if (hit(reg_addr, `RA_TG_HSHIGH)) reg_rdata_ff <= 32'(hsh_ff);
            if (hit(reg_addr, `RA_TG_HSLOW))  reg_rdata_ff <= 32'(hsl_ff);
            if (hit(reg_addr, `RA_TG_STATUS))
               reg_rdata_ff <= 32'({st_ff, locked_ff});
         end
      end
   end
endmodule

// *** verification/xbar_retimer_sva.sv ***
// port checker for the crossbar and sync retimer
`timescale 1ns/1ps
`include "xbar_params.svh"
module xbar_retimer_chk
   import xbar_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [31:0] reg_rdata_ff,
   // video
   input  wire logic [31:0] route_input_slot,
   input  wire logic [31:0] route_output_slot_ff,
   input  wire logic        locked_ff
);
   // ------------------------------------------------------------
   // shadow state
   // ------------------------------------------------------------
   logic [4:0] sel_ff [32];  // copy of slot selects
   logic [3:0] ctl_ff;       // copy of mode and regen bits
   logic [2:0] rise_ff;      // saturating count of vsync rises
   logic       vs_in;        // vsync as the generator sees it
   assign vs_in = route_input_slot[sel_ff[31]];
   // selects and control follow writes with the design's latency
   always_ff @(posedge clk) begin
      if (!resetn) begin
         for (int i = 0; i < 32; i++)
            sel_ff[i] <= 5'(i);
         ctl_ff <= 4'h0;
      end else if (reg_wr && reg_addr[7:5] == 3'h1) begin
         sel_ff[reg_addr[4:0]] <= reg_wdata[4:0];
      end else if (reg_wr && reg_addr == `RA_TG_CTRL) begin
         ctl_ff <= reg_wdata[3:0];
      end
   end
   // rises seen since tracking began; saturates, so relock is loose
   always_ff @(posedge clk) begin
      if (!resetn || ctl_ff[1:0] != MODE_TRACK) begin
         rise_ff <= 3'h0;
      end else if ($rose(vs_in) && rise_ff != 3'h7) begin
         rise_ff <= rise_ff + 3'h1;
      end
   end
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   rst_clear_a: assert property (disable iff (1'b0) !resetn |=>
      route_output_slot_ff == 32'h0 && !locked_ff && reg_rdata_ff == 32'h0)
      else $error("outputs not cleared by reset");
   rd_idle_a: assert property (!reg_rd |=> reg_rdata_ff == 32'h0)
      else $error("read data outside read slot");
   unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h0 |=>
      reg_rdata_ff == 32'h0) else $error("unmapped read not zero");
   low_readback_a: assert property (reg_wr && reg_addr == `RA_TG_LOW ##1
      !reg_wr ##1 reg_rd && reg_addr == `RA_TG_LOW |=> reg_rdata_ff ==
      {8'h0, $past(reg_wdata[23:0], 3)}) else $error("low period lost");
   status_lock_a: assert property (reg_rd && reg_addr == `RA_TG_STATUS |=>
      reg_rdata_ff[0] == $past(locked_ff)) else $error("status lock bad");
   for (genvar j = 0; j < 32; j++) begin : g_route
      route_bit_a: assert property (
         $stable(ctl_ff) && !(j == 31 && ctl_ff[2]) && !(j == 30 && ctl_ff[3])
         |=> route_output_slot_ff[j] == $past(route_input_slot[sel_ff[j]]))
         else $error("routed bit wrong");
   end
   lock_mode_a: assert property (
      (ctl_ff[1:0] != MODE_TRACK) [*2] |-> !locked_ff)
      else $error("lock outside tracking");
   lock_rises_a: assert property (
      $rose(locked_ff) |-> rise_ff >= 3'h3) else $error("lock too early");
endmodule
bind video_crossbar_sync_retimer xbar_retimer_chk xbar_retimer_chk_i (
   .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
   .route_input_slot(route_input_slot),
   .route_output_slot_ff(route_output_slot_ff), .locked_ff(locked_ff));

// *** verification/video_source_model.sv ***
// camera-like source of pixel bits with vsync and hsync
`timescale 1ns/1ps
module video_source_model (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // waveform knobs in cycles; high of zero silences vsync
   input  wire logic [7:0]  vs_high,
   input  wire logic [7:0]  vs_low,
   input  wire logic        glitch,
   input  wire logic [29:0] data,
   // pixel word: vsync, hsync, data
   output logic      [31:0] pix
);
   logic [7:0] cnt_ff;  // place within the vsync period
   // period counter; >= copes with knobs shrinking mid-period
   always_ff @(posedge clk) begin
      if (!resetn || cnt_ff >= vs_high + vs_low - 8'h1) begin
         cnt_ff <= 8'h0;
      end else begin
         cnt_ff <= cnt_ff + 8'h1;
      end
   end
   // word changes only after an edge, glitch flips vsync one cycle
   always_ff @(posedge clk) begin
      pix <= {(cnt_ff < vs_high) ^ glitch, cnt_ff[1], data};
   end
endmodule

// *** verification/video_crossbar_sync_retimer_test.sv ***
// self-checking bench for the crossbar and sync retimer
`timescale 1ns/1ps
module video_crossbar_sync_retimer_test
   import xbar_pkg::*;
   ;
   logic        clk, resetn, reg_wr, reg_rd, glitch, locked_ff, vs_q, hs_q;
   logic [7:0]  reg_addr, vs_high, vs_low;
   logic [31:0] reg_wdata, reg_rdata_ff, pix, out, prev, s, rnd, v, hn;
   logic [29:0] data;
   logic [4:0]  sel_q [32];  // selects the bench has written
   int          err_count, cmp_count;
   wire         rise = out[31] & ~vs_q;  // generated vsync rising
   logic [31:0] rst_v [8] = '{32'h0, 32'h10, 32'h100, 32'h4, 32'h0,
                              32'h0, 32'h8, 32'h20};
   // mode, gen high, gen low, src high, src low, expected period
   logic [47:0] tab [4] = '{48'h0202_0403_1114, 48'h020a_1e03_1114,
                            48'h030a_1e03_1114, 48'h0302_0400_fa06};
   video_source_model video_source_model_i (.clk(clk), .resetn(resetn),
      .vs_high(vs_high), .vs_low(vs_low), .glitch(glitch), .data(data),
      .pix(pix));
   video_crossbar_sync_retimer video_crossbar_sync_retimer_i (.clk(clk),
      .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
      .route_input_slot(pix), .route_output_slot_ff(out),
      .locked_ff(locked_ff));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [31:0] route(input logic [31:0] in);
      logic [31:0] r;
      for (int j = 0; j < 32; j++)
         r[j] = in[sel_q[j]];
      return r;
   endfunction
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // each access leaves one idle edge so strobes never double-drive
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata_ff;
      @(posedge clk);
   endtask
   task automatic wait_lock(input logic lvl);
      int n = 0;
      while (locked_ff !== lvl && n < 400) begin
         @(negedge clk);
         n++;
      end
      if (n >= 400) begin
         err_count++;
         complete_run();
      end
      @(posedge clk);
   endtask
   // cycles between two rises of the generated vsync
   task automatic per(output logic [31:0] p);
      int n = 0;
      p = 32'h0;
      do begin @(negedge clk); n++; end while (!rise && n < 300);
      do begin @(negedge clk); p++; n++; end while (!rise && n < 600);
      if (n >= 600) begin
         err_count++;
         complete_run();
      end
      @(posedge clk);
   endtask
   // input vsync rise to generated rise in cycles, then derived hsync
   // pulses counted over the rest of that generated frame
   task automatic lat(output logic [31:0] d, output logic [31:0] h);
      logic q;
      int   n;
      n = 0;
      d = 32'h0;
      h = 32'h0;
      do begin q = pix[31]; @(negedge clk); n++; end
         while (!(pix[31] && !q) && n < 300);
      do begin @(negedge clk); d++; n++; end while (!rise && n < 600);
      // window covers high and low phases but ends before the next frame
      repeat (36) begin
         @(negedge clk);
         if (out[30] && !hs_q) h++;
      end
      if (n >= 600) begin
         err_count++;
         complete_run();
      end
      @(posedge clk);
   endtask
   // ------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      rnd <= lfsr(rnd);
      data <= rnd[29:0];
      vs_q <= out[31];
      hs_q <= out[30];
   end
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      complete_run();
   end
   initial begin
      {reg_wr, reg_rd, glitch, resetn} = 4'h0;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      {vs_high, vs_low} = 16'h0305;
      data = 30'h0;
      rnd = 32'h11;
      s = 32'h11;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         rd(8'h40 + 8'(i), v);
         cmp(v, rst_v[i]);
      end
      for (int i = 0; i < 32; i++) begin
         rd(8'h20 + 8'(i), v);
         sel_q[i] = 5'(i);
         cmp(v, 32'(i));
      end
      // unmapped write then read, then a write read straight back
      wr(8'h0, 32'hffff_ffff);
      rd(8'h0, v);
      cmp(v, 32'h0);
      s = lfsr(s);
      wr(8'h42, s);
      rd(8'h42, v);
      cmp(v, {8'h0, s[23:0]});
      // random routing with slot 1 duplicating slot 0
      for (int j = 0; j < 30; j++) begin
         s = lfsr(s);
         sel_q[j] = (j == 1) ? sel_q[0] : s[4:0];
         wr(8'h20 + 8'(j), {27'h0, sel_q[j]});
      end
      @(negedge clk);
      for (int k = 0; k < 40; k++) begin
         prev = pix;
         @(negedge clk);
         cmp(out, route(prev));
      end
      @(posedge clk);
      // tracking with vsync regenerated, hsync passed through
      wr(8'h40, 32'h5);
      wait_lock(1'b1);
      rd(8'h45, v);
      cmp(v & 32'h1, 32'h1);
      per(v);
      cmp(v, 32'h8);
      glitch <= 1'b1;
      @(posedge clk);
      glitch <= 1'b0;
      per(v);
      cmp({v[30:0], locked_ff}, {31'h8, 1'b1});
      vs_low <= 8'h9;
      wait_lock(1'b0);
      wait_lock(1'b1);
      per(v);
      cmp({v[30:0], locked_ff}, {31'hc, 1'b1});
      // single and autorun, short and cut-short frames
      for (int r = 0; r < 4; r++) begin
         wr(8'h41, {24'h0, tab[r][39:32]});
         wr(8'h42, {24'h0, tab[r][31:24]});
         vs_high <= tab[r][23:16];
         vs_low <= tab[r][15:8];
         wr(8'h40, {24'h0, tab[r][47:40] | 8'h4});
         per(v);
         per(v);
         cmp(v, {24'h0, tab[r][7:0]});
      end
      // single trigger with delay, both syncs regenerated, hsync derived
      wr(8'h43, 32'h3);
      wr(8'h44, 32'h5);
      wr(8'h46, 32'h2);
      wr(8'h47, 32'h3);
      wr(8'h42, 32'h1e);
      vs_high <= 8'h3;
      vs_low <= 8'h25;
      wr(8'h40, 32'he);
      lat(v, hn);
      // delay of 5 plus input sample and output register
      cmp(v, 32'h7);
      cmp(hn, 32'h3);
      complete_run();
   end
endmodule
